// file: nvmw_pkg.sv
// Constants and types of the nvm write and programming-link block
package nvmw_pkg;
    // Register offsets, byte addresses
    localparam logic [7:0] OFS_RTS = 8'h00;
    localparam logic [7:0] OFS_FPP = 8'h04;
    localparam logic [7:0] OFS_FUP = 8'h08;
    localparam logic [7:0] OFS_PGS = 8'h0c;
    // Field positions
    localparam int RTS_ABORT_BIT = 0;
    localparam int RTS_PROT_BIT = 1;
    localparam int PGS_MODE_BIT = 8;
    // Reset values of the protection window
    localparam logic [7:0] FPP_RST = 8'h00;
    localparam logic [7:0] FUP_RST = 8'h00;
    // Link addresses, mode and command codes
    localparam logic [7:0] ADDR_W = 8'ha0;
    localparam logic [7:0] ADDR_R = 8'ha1;
    localparam logic [7:0] MODE_CODE = 8'h00;
    localparam logic [7:0] CMD_SET_PAGE = 8'h01;
    localparam logic [7:0] CMD_BYTE_WRITE = 8'h02;
    localparam logic [7:0] CMD_BYTE_READ = 8'h03;
    localparam logic [7:0] CMD_STATUS_READ = 8'h04;
    // Error codes, low seven bits of the status byte
    localparam logic [6:0] ERR_WRONG_CMD = 7'h05;
    localparam logic [6:0] ERR_NOT_ALLOWED = 7'h06;
    localparam logic [6:0] ERR_WRONG_MODE = 7'h10;
    // Lock page and the always readable block in it
    localparam logic [7:0] LOCK_PAGE = 8'h30;
    localparam logic [2:0] ID_BLOCK = 3'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int BLK_BYTES = 32;
    // Write time
    localparam int WR_TIME_NS = 4500000;
    localparam int CLK_NS = 40;
    localparam int WR_CYC_DEF = WR_TIME_NS / CLK_NS;
    localparam int TMR_W = 20;

    typedef enum logic [2:0] {LK_IDLE, LK_RECV, LK_ACK, LK_SEND, LK_RACK, LK_IGN} nvmw_lk_t;
    typedef enum logic [2:0] {PH_CMD, PH_PAGE, PH_WOFS, PH_WDATA, PH_ROFS} nvmw_ph_t;

    typedef struct packed {
        logic                       we;
        logic                       blk;
        logic [7:0]                 page;
        logic [7:0]                 ofs;
        logic [7:0]                 data;
        logic [BLK_BYTES*8-1:0]     blk_data;
    } nvmw_mem_t;

    typedef struct packed {
        logic scl_m; logic scl_s; logic scl_p;
        logic sda_m; logic sda_s; logic sda_p;
        nvmw_lk_t lk; logic [3:0] bcnt; logic [7:0] sh;
        logic first; logic rd_go; logic ign; logic rd_sts; logic mack; logic sda_oe;
        logic in_mode; logic locked; logic err_pend; logic [6:0] err_code; logic sts_armed;
        nvmw_ph_t ph; logic [7:0] page; logic [7:0] ofs;
        logic [7:0] rt_page; logic rt_busy; logic [TMR_W-1:0] tmr;
        logic wr_aborted; logic pg_protected; logic [7:0] lo_pg; logic [7:0] hi_pg;
        nvmw_mem_t rt; nvmw_mem_t mem; logic [31:0] rdata;
    } nvmw_state_t;
endpackage : nvmw_pkg

// file: nvmw_ctrl.sv
// Programming-link error handling and run-time nvm write control
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
module nvmw_ctrl #(
    parameter int WR_CYC = nvmw_pkg::WR_CYC_DEF
) (
    // Clock and reset
    input  wire logic                    CLK_SYS,
    input  wire logic                    NRST,
    // Register port
    input  wire logic [7:0]              REG_ADDR,
    input  wire logic [31:0]             REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic [31:0]                  REG_RDATA,
    // Programming link
    input  wire logic                    PROG_SCL,
    input  wire logic                    PROG_SDA,
    output logic                         PROG_SDA_DRV,
    output logic                         PROG_SDA_OE,
    input  wire logic                    LOCK_BYTE_SET,
    // Core side
    input  wire logic                    CORE_PAGE_SEL,
    input  wire logic [7:0]              CORE_PAGE_VAL,
    input  wire logic                    CORE_EXT_LOAD,
    input  wire logic [7:0]              CORE_LOAD_OFS,
    input  wire logic [7:0]              CORE_LOAD_DATA,
    input  wire logic                    CORE_BLOCK_WRITE,
    input  wire logic [7:0]              CORE_BLOCK_IDX,
    input  wire logic [255:0]            RF_BLOCK_DATA,
    input  wire logic                    IRQ_REQ,
    output logic                         CORE_HALT,
    // Memory array
    output nvmw_pkg::nvmw_mem_t          MEM_WR,
    output logic [15:0]                  MEM_RADDR,
    input  wire logic [7:0]              MEM_RDATA
);

    generate
        if (WR_CYC < 2 || WR_CYC >= (1 << nvmw_pkg::TMR_W)) begin : g_bad
            $error("WR_CYC out of range for the write timer");
        end
    endgenerate

    nvmw_pkg::nvmw_state_t q;
    nvmw_pkg::nvmw_state_t d;
    logic                  scl_rise;
    logic                  scl_fall;
    logic                  l_start;
    logic                  l_stop;
    logic                  prot;
    logic                  rt_go;
    logic [7:0]            b;

    always_comb begin
        d = q;
        d.mem.we = 1'b0;
        d.rdata = '0;
        d.scl_m = PROG_SCL;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = PROG_SDA;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        scl_rise = q.scl_s & ~q.scl_p;
        scl_fall = ~q.scl_s & q.scl_p;
        l_start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
        l_stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
        b = q.sh;

        // Link bit level
        if (l_start) begin
            d.lk = nvmw_pkg::LK_RECV;
            d.bcnt = '0;
            d.first = 1'b1;
            d.sda_oe = 1'b0;
            d.ph = nvmw_pkg::PH_CMD;
        end else if (l_stop) begin
            d.lk = nvmw_pkg::LK_IDLE;
            d.sda_oe = 1'b0;
        end else begin
            case (q.lk)
                nvmw_pkg::LK_RECV: begin
                    if (scl_rise) begin
                        d.sh = {q.sh[6:0], q.sda_s};
                        d.bcnt = q.bcnt + 4'h1;
                    end else if (scl_fall && q.bcnt == nvmw_pkg::BITS_PER_BYTE) begin
                        d.lk = nvmw_pkg::LK_ACK;
                        d.sda_oe = 1'b1;
                        d.rd_go = 1'b0;
                        d.ign = 1'b0;
                        if (q.first) begin
                            d.first = 1'b0;
                            if (b == nvmw_pkg::ADDR_R) begin
                                d.rd_go = 1'b1;
                                d.rd_sts = q.sts_armed;
                                d.sts_armed = 1'b0;
                            end else if (b != nvmw_pkg::ADDR_W) begin
                                d.sda_oe = 1'b0;
                                d.ign = 1'b1;
                            end
                        end else if (q.err_pend) begin
                            d.sda_oe = 1'b0;
                            d.ign = 1'b1;
                            d.err_pend = 1'b0;
                        end else if (!q.in_mode) begin
                            if (b == nvmw_pkg::MODE_CODE) begin
                                d.in_mode = 1'b1;
                                d.locked = LOCK_BYTE_SET;
                            end else begin
                                d.err_code = nvmw_pkg::ERR_WRONG_MODE;
                                d.err_pend = 1'b1;
                            end
                        end else begin
                            case (q.ph)
                                nvmw_pkg::PH_CMD: begin
                                    case (b)
                                        nvmw_pkg::CMD_SET_PAGE: d.ph = nvmw_pkg::PH_PAGE;
                                        nvmw_pkg::CMD_BYTE_READ: d.ph = nvmw_pkg::PH_ROFS;
                                        nvmw_pkg::CMD_BYTE_WRITE: begin
                                            if (q.locked) begin
                                                d.err_code = nvmw_pkg::ERR_NOT_ALLOWED;
                                                d.err_pend = 1'b1;
                                            end else begin
                                                d.ph = nvmw_pkg::PH_WOFS;
                                            end
                                        end
                                        nvmw_pkg::CMD_STATUS_READ: d.sts_armed = 1'b1;
                                        default: begin
                                            d.err_code = nvmw_pkg::ERR_WRONG_CMD;
                                            d.err_pend = 1'b1;
                                        end
                                    endcase
                                end
                                nvmw_pkg::PH_PAGE: begin
                                    d.page = b;
                                    d.ph = nvmw_pkg::PH_CMD;
                                end
                                nvmw_pkg::PH_WOFS: begin
                                    d.ofs = b;
                                    d.ph = nvmw_pkg::PH_WDATA;
                                end
                                nvmw_pkg::PH_WDATA: begin
                                    d.mem.we = 1'b1;
                                    d.mem.blk = 1'b0;
                                    d.mem.page = q.page;
                                    d.mem.ofs = q.ofs;
                                    d.mem.data = b;
                                    d.ph = nvmw_pkg::PH_CMD;
                                end
                                nvmw_pkg::PH_ROFS: begin
                                    d.ph = nvmw_pkg::PH_CMD;
                                    // only the id block while locked
                                    if (q.locked && !(q.page == nvmw_pkg::LOCK_PAGE
                                        && b[7:5] == nvmw_pkg::ID_BLOCK)) begin
                                        d.err_code = nvmw_pkg::ERR_NOT_ALLOWED;
                                        d.err_pend = 1'b1;
                                    end else begin
                                        d.ofs = b;
                                    end
                                end
                                default: d.ph = nvmw_pkg::PH_CMD;
                            endcase
                        end
                    end
                end
                nvmw_pkg::LK_ACK: begin
                    if (scl_fall) begin
                        d.bcnt = '0;
                        d.sda_oe = 1'b0;
                        if (q.ign) begin
                            d.lk = nvmw_pkg::LK_IGN;
                        end else if (q.rd_go) begin
                            d.lk = nvmw_pkg::LK_SEND;
                            // lock bit above the error code
                            d.sh = q.rd_sts ? {q.locked, q.err_code} : MEM_RDATA;
                            d.sda_oe = q.rd_sts ? ~q.locked : ~MEM_RDATA[7];
                        end else begin
                            d.lk = nvmw_pkg::LK_RECV;
                        end
                    end
                end
                nvmw_pkg::LK_SEND: begin
                    if (scl_rise) begin
                        d.bcnt = q.bcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (q.bcnt == nvmw_pkg::BITS_PER_BYTE) begin
                            d.lk = nvmw_pkg::LK_RACK;
                            d.sda_oe = 1'b0;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_oe = ~q.sh[6];
                        end
                    end
                end
                nvmw_pkg::LK_RACK: begin
                    if (scl_rise) begin
                        d.mack = ~q.sda_s & ~q.rd_sts;
                        if (!q.sda_s && !q.rd_sts) begin
                            d.ofs = q.ofs + 8'h01;
                        end
                    end else if (scl_fall) begin
                        d.bcnt = '0;
                        // Next address had several cycles to settle
                        if (q.mack) begin
                            d.lk = nvmw_pkg::LK_SEND;
                            d.sh = MEM_RDATA;
                            d.sda_oe = ~MEM_RDATA[7];
                        end else begin
                            d.lk = nvmw_pkg::LK_IGN;
                        end
                    end
                end
                nvmw_pkg::LK_IGN: d.sda_oe = 1'b0;
                nvmw_pkg::LK_IDLE: d.sda_oe = 1'b0;
                default: d.lk = nvmw_pkg::LK_IDLE;
            endcase
        end

        // Run-time writes
        if (CORE_PAGE_SEL && !q.rt_busy) begin
            d.rt_page = CORE_PAGE_VAL;
        end
        // window, empty when bounds are equal
        prot = (q.rt_page >= q.lo_pg) && (q.rt_page < q.hi_pg);
        rt_go = !q.rt_busy && (CORE_EXT_LOAD || CORE_BLOCK_WRITE);
        if (rt_go) begin
            if (prot) begin
                d.pg_protected = 1'b1;
            end else begin
                d.rt_busy = 1'b1;
                d.tmr = nvmw_pkg::TMR_W'(WR_CYC - 1);
                d.rt.page = q.rt_page;
                d.rt.blk = CORE_BLOCK_WRITE;
                d.rt.data = CORE_LOAD_DATA;
                d.rt.blk_data = RF_BLOCK_DATA;
                d.rt.ofs = CORE_BLOCK_WRITE ? {CORE_BLOCK_IDX[2:0], 5'h00} : CORE_LOAD_OFS;
            end
        end else if (q.rt_busy) begin
            if (IRQ_REQ) begin
                d.rt_busy = 1'b0;
                d.wr_aborted = 1'b1;
            end else if (q.tmr == '0) begin
                d.rt_busy = 1'b0;
                d.mem = q.rt;
                d.mem.we = 1'b1;
            end else begin
                d.tmr = q.tmr - nvmw_pkg::TMR_W'(1);
            end
        end
        // success clears both flags; a same-cycle abort or refusal wins
        if (d.mem.we && !(q.rt_busy && IRQ_REQ)) begin
            d.wr_aborted = 1'b0;
        end
        if (d.mem.we && !(rt_go && prot)) begin
            d.pg_protected = 1'b0;
        end
        // Programming write wins a same-cycle collision; core is halted then anyway
        if (q.lk == nvmw_pkg::LK_RECV && d.lk == nvmw_pkg::LK_ACK && q.ph == nvmw_pkg::PH_WDATA
            && q.in_mode && !q.first && !q.err_pend) begin
            d.mem.blk = 1'b0;
            d.mem.page = q.page;
            d.mem.ofs = q.ofs;
            d.mem.data = b;
        end

        // Register port
        if (REG_WR) begin
            case (REG_ADDR)
                nvmw_pkg::OFS_FPP: d.lo_pg = REG_WDATA[7:0];
                nvmw_pkg::OFS_FUP: d.hi_pg = REG_WDATA[7:0];
                default: d.rdata = '0;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                nvmw_pkg::OFS_RTS: begin
                    d.rdata[nvmw_pkg::RTS_ABORT_BIT] = q.wr_aborted;
                    d.rdata[nvmw_pkg::RTS_PROT_BIT] = q.pg_protected;
                end
                nvmw_pkg::OFS_FPP: d.rdata[7:0] = q.lo_pg;
                nvmw_pkg::OFS_FUP: d.rdata[7:0] = q.hi_pg;
                nvmw_pkg::OFS_PGS: begin
                    d.rdata[7:0] = {q.locked, q.err_code};
                    d.rdata[nvmw_pkg::PGS_MODE_BIT] = q.in_mode;
                end
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            q <= '0;
            q.scl_m <= 1'b1;
            q.scl_s <= 1'b1;
            q.scl_p <= 1'b1;
            q.sda_m <= 1'b1;
            q.sda_s <= 1'b1;
            q.sda_p <= 1'b1;
            q.lo_pg <= nvmw_pkg::FPP_RST;
            q.hi_pg <= nvmw_pkg::FUP_RST;
        end else begin
            q <= d;
        end
    end

    assign REG_RDATA = q.rdata;
    assign PROG_SDA_DRV = 1'b0;
    assign PROG_SDA_OE = q.sda_oe;
    assign CORE_HALT = q.rt_busy;
    assign MEM_WR = q.mem;
    assign MEM_RADDR = {q.page, q.ofs};

    AST_NACK_AFTER_ERR: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        q.err_pend && q.lk == nvmw_pkg::LK_RECV && scl_fall && q.bcnt == nvmw_pkg::BITS_PER_BYTE
        && !q.first && !l_start && !l_stop |=> q.lk == nvmw_pkg::LK_ACK && !PROG_SDA_OE && q.ign)
        else $error("byte after an error was acknowledged");
    AST_STATUS_MSB: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        q.lk == nvmw_pkg::LK_ACK && scl_fall && q.rd_go && q.rd_sts && !q.ign && !l_start && !l_stop
        |=> q.sh == {q.locked, q.err_code})
        else $error("status byte does not carry lock bit and error code");
    AST_HALT_HELD: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        q.rt_busy && !IRQ_REQ && q.tmr != '0 |=> CORE_HALT && !MEM_WR.we)
        else $error("core released before the write finished");
    AST_IRQ_ABORT: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        q.rt_busy && IRQ_REQ |=> !CORE_HALT && q.wr_aborted && !MEM_WR.we)
        else $error("interrupt did not abort the write");
    AST_COMMIT: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        q.rt_busy && !IRQ_REQ && q.tmr == '0 |=> MEM_WR.we && !CORE_HALT && MEM_WR.page == $past(q.rt.page))
        else $error("write did not commit at the end of the write time");
    AST_BLOCK_SRC: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        $rose(q.rt_busy) && $past(CORE_BLOCK_WRITE) |-> q.rt.blk && q.rt.blk_data == $past(RF_BLOCK_DATA)
        && q.rt.ofs[4:0] == 5'h00)
        else $error("block write did not capture the register file block");
    AST_PROT_ABORT: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        rt_go && q.rt_page >= q.lo_pg && q.rt_page < q.hi_pg |=> q.pg_protected && !q.rt_busy)
        else $error("write to a protected page was not refused");
    AST_EQUAL_BOUNDS: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        rt_go && q.lo_pg == q.hi_pg |=> q.rt_busy && $stable(q.pg_protected))
        else $error("equal bounds still protected a page");
    AST_FLAGS_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        MEM_WR.we && !$past(q.rt_busy && IRQ_REQ) && !$past(rt_go && prot) |-> !q.wr_aborted && !q.pg_protected)
        else $error("abort flags survived a successful write");

endmodule : nvmw_ctrl

// file: nvmw_prog.sv
// Two-wire programmer model for the programming link
`timescale 1ns/1ns
module nvmw_prog (
    // Link, data released means pulled up
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic start();
        // Offset pairs with the short tail of stop, so link edges sit between clock edges
        #10 sda_m = 1'b0;
        #160 scl = 1'b0;
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        #80 scl = 1'b1;
        #160 sda_m = 1'b1;
        #150;
    endtask : stop
    // sends only what it is given, never id bytes
    task automatic xfer(input logic [7:0] d, input logic mnack, output logic [7:0] r, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_m = (i == 0) ? mnack : d[i-1];
            #80 scl = 1'b1;
            #80 if (i > 0) r[i-1] = sda; else ack = ~sda;
            #80 scl = 1'b0;
            #80;
        end
    endtask : xfer
endmodule : nvmw_prog

// file: nvmw_ctrl_bench.sv
// Self-checking bench of the nvm write and programming-link block
`timescale 1ns/1ns
module nvmw_ctrl_bench;
    localparam int WR = 20;
    logic                clk, nrst, wr, rd, lock, psel, eload, bwr, irq, scl, sda_m, sda_oe, sda_o, halt, ack, pr;
    logic [7:0]          addr, page, ofs, dat, idx, mrd, r8, p, bad;
    logic [31:0]         wdata, rdata, got;
    logic [255:0]        rf;
    logic [15:0]         raddr;
    nvmw_pkg::nvmw_mem_t mw, last;
    int                  bad_count, tests_run, seed, hcnt, wcnt, w0;
    wire                 sda = sda_oe ? sda_o : sda_m;
    nvmw_ctrl #(.WR_CYC(WR)) nvmw_ctrl_inst (.CLK_SYS(clk), .NRST(nrst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PROG_SCL(scl), .PROG_SDA(sda), .PROG_SDA_DRV(sda_o),
        .PROG_SDA_OE(sda_oe), .LOCK_BYTE_SET(lock), .CORE_PAGE_SEL(psel), .CORE_PAGE_VAL(page),
        .CORE_EXT_LOAD(eload), .CORE_LOAD_OFS(ofs), .CORE_LOAD_DATA(dat), .CORE_BLOCK_WRITE(bwr),
        .CORE_BLOCK_IDX(idx), .RF_BLOCK_DATA(rf), .IRQ_REQ(irq), .CORE_HALT(halt), .MEM_WR(mw),
        .MEM_RADDR(raddr), .MEM_RDATA(mrd));
    nvmw_prog nvmw_prog_inst (.scl(scl), .sda_m(sda_m), .sda(sda));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (halt === 1'b1) hcnt <= hcnt + 1;
        if (mw.we === 1'b1) begin
            wcnt <= wcnt + 1;
            last <= mw;
        end
    end
    function automatic logic prot(input logic [7:0] pg, lo, hi);
        return lo <= pg && pg < hi;
    endfunction : prot
    task automatic chk(input logic [255:0] g, e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask : chk
    task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {addr, wdata, wr, rd} <= {a, d, w, ~w};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1 got = rdata;
    endtask : reg_io
    task automatic reset(input logic lk);
        {nrst, lock} <= {1'b0, lk};
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
    endtask : reset
    task automatic core(input logic b, input logic [7:0] pg, x);
        @(posedge clk);
        {psel, page} <= {1'b1, pg};
        @(posedge clk);
        {psel, eload, bwr, ofs, idx, dat} <= {1'b0, ~b, b, x, x, x ^ 8'h5a};
        @(posedge clk);
        {eload, bwr} <= 2'b00;
        #1 hcnt = 0;
        w0 = wcnt;
    endtask : core
    task automatic results();
        $display("counts: %0d compared, %0d wrong", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    initial begin
        #1000000 bad_count++;
        results();
    end
    initial begin
        {seed, bad_count, tests_run, wcnt, hcnt} = {32'd29, 128'd0};
        {nrst, wr, rd, psel, eload, bwr, irq, lock, addr, wdata, page, ofs, dat, idx, rf} = '0;
        mrd = $random(seed);
        // Wrong mode, unknown command, forbidden while locked
        for (int k = 0; k < 3; k++) begin
            reset(k == 2);
            bad = (k == 0) ? 8'($random(seed)) | 8'h01 : (k == 1) ? 8'h99 : nvmw_pkg::CMD_BYTE_WRITE;
            nvmw_prog_inst.start();
            nvmw_prog_inst.xfer(nvmw_pkg::ADDR_W, 1'b1, r8, ack);
            if (k > 0) nvmw_prog_inst.xfer(nvmw_pkg::MODE_CODE, 1'b1, r8, ack);
            nvmw_prog_inst.xfer(bad, 1'b1, r8, ack);
            chk(ack, 1'b1);
            nvmw_prog_inst.xfer(nvmw_pkg::CMD_SET_PAGE, 1'b1, r8, ack);
            chk(ack, 1'b0);
            nvmw_prog_inst.stop();
            nvmw_prog_inst.start();
            nvmw_prog_inst.xfer(nvmw_pkg::ADDR_W, 1'b1, r8, ack);
            // Mode never entered after a wrong mode byte, so enter it before asking for status
            if (k == 0) nvmw_prog_inst.xfer(nvmw_pkg::MODE_CODE, 1'b1, r8, ack);
            nvmw_prog_inst.xfer(nvmw_pkg::CMD_STATUS_READ, 1'b1, r8, ack);
            nvmw_prog_inst.stop();
            nvmw_prog_inst.start();
            nvmw_prog_inst.xfer(nvmw_pkg::ADDR_R, 1'b1, r8, ack);
            nvmw_prog_inst.xfer(8'hff, 1'b1, r8, ack);
            nvmw_prog_inst.stop();
            chk(r8, (k == 0) ? {1'b0, nvmw_pkg::ERR_WRONG_MODE} : (k == 1) ? {1'b0, nvmw_pkg::ERR_WRONG_CMD}
                : {1'b1, nvmw_pkg::ERR_NOT_ALLOWED});
        end
        $display("test link errors done");
        reset(1'b0);
        reg_io(1'b0, nvmw_pkg::OFS_FUP, 0);
        chk(got, nvmw_pkg::FUP_RST);
        reg_io(1'b1, nvmw_pkg::OFS_FPP, 5);
        reg_io(1'b1, nvmw_pkg::OFS_FUP, 8);
        reg_io(1'b0, nvmw_pkg::OFS_FPP, 0);
        chk(got, 5);
        reg_io(1'b0, 8'h10, 0);
        chk(got, 0);
        // Programming write to protected page 6, then read back through the link
        p = 8'($random(seed));
        w0 = wcnt;
        nvmw_prog_inst.start();
        nvmw_prog_inst.xfer(nvmw_pkg::ADDR_W, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(nvmw_pkg::MODE_CODE, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(nvmw_pkg::CMD_SET_PAGE, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(8'h06, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(nvmw_pkg::CMD_BYTE_WRITE, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(p, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(~p, 1'b1, r8, ack);
        chk(ack, 1'b1);
        nvmw_prog_inst.xfer(nvmw_pkg::CMD_BYTE_READ, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(p, 1'b1, r8, ack);
        nvmw_prog_inst.stop();
        chk({wcnt - w0, last.blk, last.page, last.ofs, last.data}, {32'd1, 1'b0, 8'h06, p, ~p});
        nvmw_prog_inst.start();
        nvmw_prog_inst.xfer(nvmw_pkg::ADDR_R, 1'b1, r8, ack);
        nvmw_prog_inst.xfer(8'hff, 1'b1, r8, ack);
        nvmw_prog_inst.stop();
        chk({r8, raddr}, {mrd, 8'h06, p});
        reg_io(1'b0, nvmw_pkg::OFS_PGS, 0);
        chk(got, 32'h100);
        $display("test programming write done");
        // Pages 4,5,7,8 around bounds 5 and 8, then random pages, last with equal bounds
        for (int i = 0; i < 8; i++) begin
            p = (i < 4) ? 8'(4 + i + (i > 1)) : (i == 7) ? 8'h05 : 8'($random(seed));
            if (i == 7) reg_io(1'b1, nvmw_pkg::OFS_FUP, 5);
            pr = prot(p, 8'h05, (i == 7) ? 8'h05 : 8'h08);
            core(1'b0, p, 8'(i));
            repeat (WR + 4) @(posedge clk);
            chk(hcnt, pr ? 0 : WR);
            chk(wcnt - w0, !pr);
            if (!pr) chk({last.blk, last.page, last.ofs, last.data}, {1'b0, p, 8'(i), 8'(i) ^ 8'h5a});
            reg_io(1'b0, nvmw_pkg::OFS_RTS, 0);
            chk(got, pr ? 2 : 0);
        end
        $display("test protection done");
        core(1'b0, 8'h20, 8'h01);
        repeat (4) @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
        repeat (3) @(posedge clk);
        chk(halt, 1'b0);
        chk(wcnt - w0, 0);
        reg_io(1'b0, nvmw_pkg::OFS_RTS, 0);
        chk(got, 1);
        @(posedge clk);
        for (int j = 0; j < 8; j++) rf[32*j+:32] <= $random(seed);
        core(1'b1, 8'h21, 8'h09);
        repeat (WR + 4) @(posedge clk);
        chk({last.blk, last.page, last.ofs}, {1'b1, 8'h21, 8'h20});
        chk(last.blk_data, rf);
        reg_io(1'b0, nvmw_pkg::OFS_RTS, 0);
        chk(got, 0);
        $display("test abort and block done");
        results();
    end
endmodule : nvmw_ctrl_bench
